/* hdl/sram_byte_write_mask_regs.vh */
// constants for the write-port lane masking block
`ifndef SRAM_BYTE_WRITE_MASK_REGS_VH
`define SRAM_BYTE_WRITE_MASK_REGS_VH
`define DATA_W 36
`define LANES 4
`define LANE_W 9
`define NIBBLE_W 4
`define ADDR_W 4
`define CFG_X8 2'h0
`define CFG_X9 2'h1
`define CFG_X18 2'h2
`define CFG_X36 2'h3
`define SYNC_DEPTH 3
`endif

/* hdl/sram_byte_write_mask.v */
// write-port lane masking with a small storage array and read-back port
`timescale 1ns/1ps
`include "sram_byte_write_mask_regs.vh"
module sram_byte_write_mask (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [1:0] width_cfg_i,
	input wire k_i,
	input wire k_n_i,
	input wire write_port_select_n_i,
	input wire [`ADDR_W-1:0] wr_addr_i,
	input wire [`DATA_W-1:0] wr_data_i,
	input wire [`LANES-1:0] lane_write_select_n_i,
	input wire [1:0] half_byte_write_select_n_i,
	input wire rd_en_i,
	input wire [`ADDR_W:0] rd_word_i,
	output reg [`DATA_W-1:0] rd_data_o,
	output reg rd_data_oe_o,
	output reg write_busy_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WORD1 = 1'b1;
	localparam PIN_W = 2 + `ADDR_W + `DATA_W + `LANES + 3;

	// width strap
	reg [1:0] cfg_ff;

	// pin pipeline and clock edge filters
	reg [PIN_W-1:0] s1_ff;
	reg [PIN_W-1:0] s2_ff;
	reg [PIN_W-1:0] s3_ff;
	reg k_flt_ff;
	reg kn_flt_ff;

	// write sequencer
	reg state_ff;
	reg [`ADDR_W-1:0] addr_ff;
	reg [`DATA_W-1:0] mem [0:(1<<(`ADDR_W+1))-1];
	reg nxt_state;
	reg wr_en;
	reg [`ADDR_W:0] wr_idx;

	// fields of the third pipeline stage
	wire [PIN_W-1:0] pins;
	wire k_rise;
	wire kn_rise;
	wire s_wps_n;
	wire [`ADDR_W-1:0] s_addr;
	wire [`DATA_W-1:0] s_data;
	wire [`LANES-1:0] s_lane_n;
	wire [1:0] s_half_n;

	// masked merge of one word
	wire [`DATA_W-1:0] bit_en;
	wire [`DATA_W-1:0] kept_bits;
	wire [`DATA_W-1:0] new_bits;
	wire [`DATA_W-1:0] merged;

	assign pins = {k_i, k_n_i, write_port_select_n_i, wr_addr_i, wr_data_i,
		lane_write_select_n_i, half_byte_write_select_n_i};
	assign s_wps_n = s3_ff[PIN_W-3];
	assign s_addr = s3_ff[`DATA_W+`LANES+2 +: `ADDR_W];
	assign s_data = s3_ff[`LANES+2 +: `DATA_W];
	assign s_lane_n = s3_ff[2 +: `LANES];
	assign s_half_n = s3_ff[1:0];
	// a clock edge counts once stages two and three agree
	assign k_rise = s2_ff[PIN_W-1] & s3_ff[PIN_W-1] & ~k_flt_ff;
	assign kn_rise = s2_ff[PIN_W-2] & s3_ff[PIN_W-2] & ~kn_flt_ff;

	// strap caught while reset is held
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cfg_ff <= width_cfg_i;
		end
	end

	// three-stage pin pipeline
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s1_ff <= {PIN_W{1'b0}};
			s2_ff <= {PIN_W{1'b0}};
			s3_ff <= {PIN_W{1'b0}};
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// filtered levels start high, then drop with the cleared stages: a pin high at reset still gives an edge
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			k_flt_ff <= 1'b1;
			kn_flt_ff <= 1'b1;
		end else begin
			if (s2_ff[PIN_W-1] == s3_ff[PIN_W-1]) begin
				k_flt_ff <= s3_ff[PIN_W-1];
			end
			if (s2_ff[PIN_W-2] == s3_ff[PIN_W-2]) begin
				kn_flt_ff <= s3_ff[PIN_W-2];
			end
		end
	end

	// per-bit write enable from the selects of this portion
	genvar b;
	generate
		for (b = 0; b < `DATA_W; b = b + 1) begin : g_bit
			wire en_x8;
			wire en_x9;
			wire en_x18;
			wire en_x36;
			// nibble selects reach only the low byte
			if (b < 2 * `NIBBLE_W) begin : g_x8
				assign en_x8 = ~s_half_n[b / `NIBBLE_W];
			end else begin : g_x8_off
				assign en_x8 = 1'b0;
			end
			if (b < `LANE_W) begin : g_x9
				assign en_x9 = ~s_lane_n[0];
			end else begin : g_x9_off
				assign en_x9 = 1'b0;
			end
			if (b < 2 * `LANE_W) begin : g_x18
				assign en_x18 = ~s_lane_n[b / `LANE_W];
			end else begin : g_x18_off
				assign en_x18 = 1'b0;
			end
			assign en_x36 = ~s_lane_n[b / `LANE_W];
			// bits above the configured width never change
			assign bit_en[b] = (cfg_ff == `CFG_X8) ? en_x8 :
				(cfg_ff == `CFG_X9) ? en_x9 :
				(cfg_ff == `CFG_X18) ? en_x18 : en_x36;
		end
	endgenerate

	// word0 on the filtered K rise, word1 on the next K# rise
	// a K rise while word1 is pending is ignored
	always @* begin
		nxt_state = state_ff;
		wr_en = 1'b0;
		wr_idx = {addr_ff, 1'b1};
		case (state_ff)
			ST_IDLE: begin
				if (k_rise && !s_wps_n) begin
					wr_en = 1'b1;
					wr_idx = {s_addr, 1'b0};
					nxt_state = ST_WORD1;
				end
			end
			ST_WORD1: begin
				if (kn_rise) begin
					wr_en = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// unselected lanes keep the stored bits; all high stores nothing new
	assign kept_bits = mem[wr_idx] & ~bit_en;
	assign new_bits = s_data & bit_en;
	assign merged = kept_bits | new_bits;

	// array write of one masked word; reset leaves contents alone
	always @(posedge mclk_i) begin
		if (wr_en) begin
			mem[wr_idx] <= merged;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// address held for word1 of the same burst
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			addr_ff <= {`ADDR_W{1'b0}};
		end else if (state_ff == ST_IDLE && k_rise && !s_wps_n) begin
			addr_ff <= s_addr;
		end
	end

	// high while word1 is still owed
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			write_busy_o <= 1'b0;
		end else begin
			write_busy_o <= (nxt_state == ST_WORD1);
		end
	end

	// output enable trails the request by one cycle
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_data_oe_o <= 1'b0;
		end else begin
			rd_data_oe_o <= rd_en_i;
		end
	end

	// read-back word holds until the next request
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_data_o <= {`DATA_W{1'b0}};
		end else if (rd_en_i) begin
			rd_data_o <= mem[rd_word_i];
		end
	end
endmodule

/* test/sram_wr_ctl.sv */
// controller model driving the write-port pins
`timescale 1ns/1ps
module sram_wr_ctl (
	input wire mclk_i,
	output reg k_o,
	output reg kn_o,
	output reg wps_n_o,
	output reg [3:0] a_o,
	output reg [35:0] d_o,
	output reg [3:0] s_o
);
initial begin
	{k_o, kn_o, wps_n_o, a_o, d_o, s_o} = {3'h1, 40'h0, 4'hf};
end
task wr(input [3:0] a, input [35:0] d0, input [3:0] s0, input [35:0] d1, input [3:0] s1);
begin
	@(posedge mclk_i) {wps_n_o, a_o, d_o, s_o} <= {1'b0, a, d0, s0};
	repeat (4) @(posedge mclk_i);
	k_o <= 1'b1;
	repeat (4) @(posedge mclk_i);
	{wps_n_o, d_o, s_o} <= {1'b1, d1, s1};
	repeat (4) @(posedge mclk_i);
	kn_o <= 1'b1;
	repeat (4) @(posedge mclk_i);
	{k_o, kn_o, d_o} <= {2'h0, ~d1};
	repeat (4) @(posedge mclk_i);
end
endtask
task park;
begin
	@(posedge mclk_i) {k_o, kn_o} <= 2'h3;
	repeat (4) @(posedge mclk_i);
end
endtask
endmodule

/* test/sram_mask_properties.sv */
// read-back, write-busy and reset checks
`timescale 1ns/1ps
module sram_mask_chk (
	input wire mclk_i,
	input wire rst_n_i,
	input wire rd_en_i,
	input wire k_i,
	input wire k_n_i,
	input wire write_port_select_n_i,
	input wire rd_data_oe_o,
	input wire write_busy_o
);
sequence s_start;
	$rose(k_i) && !write_port_select_n_i && !write_busy_o;
endsequence
sequence s_busy_up;
	!write_busy_o ##1 write_busy_o;
endsequence
sequence s_second;
	$rose(k_n_i) && write_busy_o;
endsequence
sequence s_busy_down;
	write_busy_o ##1 !write_busy_o;
endsequence
property p_busy_rise;
	@(posedge mclk_i) disable iff (!rst_n_i) s_start |-> ##3 s_busy_up;
endproperty
property p_busy_fall;
	@(posedge mclk_i) disable iff (!rst_n_i) s_second |-> ##3 s_busy_down;
endproperty
property p_busy_kept;
	@(posedge mclk_i) disable iff (!rst_n_i) write_busy_o && !k_n_i |=> write_busy_o;
endproperty
property p_rst;
	@(posedge mclk_i) !rst_n_i |=> !rd_data_oe_o && !write_busy_o;
endproperty
property p_idle;
	@(posedge mclk_i) disable iff (!rst_n_i) !rd_en_i |=> !rd_data_oe_o;
endproperty
property p_oe;
	@(posedge mclk_i) disable iff (!rst_n_i) rd_en_i |=> rd_data_oe_o;
endproperty
a_rst: assert property (p_rst) else $error("busy or oe high in reset");
a_idle: assert property (p_idle) else $error("oe without read");
a_oe: assert property (p_oe) else $error("oe missing");
a_busy_rise: assert property (p_busy_rise) else $error("word0 not taken");
a_busy_fall: assert property (p_busy_fall) else $error("word1 not taken");
a_busy_kept: assert property (p_busy_kept) else $error("busy ended early");
endmodule
bind sram_byte_write_mask sram_mask_chk chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.rd_en_i(rd_en_i), .k_i(k_i), .k_n_i(k_n_i),
	.write_port_select_n_i(write_port_select_n_i), .rd_data_oe_o(rd_data_oe_o),
	.write_busy_o(write_busy_o));

/* test/tb_top.sv */
// lane masking testbench
`timescale 1ns/1ps
module tb_top;
reg mclk_i = 0, rst_n_i = 0, rd_en_i = 0;
reg [1:0] cfg = 0;
reg [4:0] rw = 0;
wire k, kn, w, oe;
wire [3:0] a, l;
wire [35:0] d, q;
reg [35:0] e0, e1, wm, v, exq[$];
integer miscompares = 0, checked = 0, seed = 32'ha0fae6ad, i, j;
sram_wr_ctl ctl_i (.mclk_i(mclk_i), .k_o(k), .kn_o(kn), .wps_n_o(w), .a_o(a), .d_o(d), .s_o(l));
sram_byte_write_mask sram_byte_write_mask_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.width_cfg_i(cfg), .k_i(k), .k_n_i(kn), .write_port_select_n_i(w), .wr_addr_i(a),
	.wr_data_i(d), .lane_write_select_n_i(l), .half_byte_write_select_n_i(l[1:0]),
	.rd_en_i(rd_en_i), .rd_word_i(rw), .rd_data_o(q), .rd_data_oe_o(oe), .write_busy_o());
function [35:0] lm(input [1:0] c, input [3:0] s);
	case (c)
	0: lm = {28'h0, {4{~s[1]}}, {4{~s[0]}}};
	1: lm = {27'h0, {9{~s[0]}}};
	2: lm = {18'h0, {9{~s[1]}}, {9{~s[0]}}};
	default: lm = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
	endcase
endfunction
task t(input [3:0] s0, input [3:0] s1);
	reg [35:0] d0, d1;
begin
	d0 = {$random(seed), $random(seed)};
	d1 = {$random(seed), $random(seed)};
	ctl_i.wr(4'h5, d0, s0, d1, s1);
	e0 = e0 & ~lm(cfg, s0) | d0 & lm(cfg, s0);
	e1 = e1 & ~lm(cfg, s1) | d1 & lm(cfg, s1);
	@(posedge mclk_i) {rd_en_i, rw} <= 6'h2a;
	exq.push_back(e0 & wm);
	@(posedge mclk_i) rw <= 5'h0b;
	exq.push_back(e1 & wm);
	@(posedge mclk_i) rd_en_i <= 1'b0;
	repeat (3) @(posedge mclk_i);
end
endtask
task stop_test;
begin
	$display("checked %0d miscompares %0d", checked, miscompares);
	if (miscompares == 0 && checked > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
end
endtask
initial begin
	forever #2.5 mclk_i = ~mclk_i;
end
initial begin
	#200000 miscompares = miscompares + 1;
	stop_test;
end
always @(posedge mclk_i) if (oe === 1'b1) begin
	checked = checked + 1;
	v = exq.pop_front();
	if ((q & wm) !== v) begin
		miscompares = miscompares + 1;
		$display("unexpected %0t %h %h", $time, q & wm, v);
	end
end
initial begin
	for (i = 0; i < 4; i = i + 1) begin
		{rst_n_i, cfg} <= {1'b0, i[1:0]};
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		wm = lm(i[1:0], 4'h0);
		t(4'h0, 4'h0);
		for (j = 0; j < 6; j = j + 1)
			t($random(seed), $random(seed));
		t(4'hf, 4'hf);
		$display("width setting %0d done", i);
	end
	ctl_i.park;
	stop_test;
end
endmodule
